// >>> hw/strobe_defs.svh
`ifndef STROBE_DEFS_SVH
`define STROBE_DEFS_SVH
`define CLKS_PER_MCYCLE 12
`define RESET_MIN_MCYCLES 2
`define HOST_RESET_MCYCLES 10
`define PORT3_RESET 8'hff
`endif

// >>> hw/strobe_pkg.sv
package strobe_pkg;
   typedef enum logic [1:0] {
      mode_reset,
      mode_normal,
      mode_host
   } op_mode_e;
endpackage

// >>> hw/mcycle_div.sv
`timescale 1ns/1ps
`include "strobe_defs.svh"
module mcycle_div #(
   parameter int CLKS = `CLKS_PER_MCYCLE
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   output logic o_phase_tick,
   output logic o_mcycle_tick,
   output logic o_half
);
   localparam int W = $clog2(CLKS + 1);
   logic [W-1:0] cnt_q;
   wire last = (cnt_q == W'(CLKS - 1));
   wire mid = (cnt_q == W'(CLKS / 2 - 1));
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= last ? '0 : cnt_q + W'(1);
      end
   end
   assign o_mcycle_tick = last;
   assign o_phase_tick = last | mid;
   assign o_half = (cnt_q >= W'(CLKS / 2));
endmodule // mcycle_div

// >>> hw/ext_bus_strobes.sv
`timescale 1ns/1ps
`include "strobe_defs.svh"
module ext_bus_strobes
   import strobe_pkg::*;
#(
   parameter int CLKS = `CLKS_PER_MCYCLE
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_reset_pin,
   input wire logic i_strobe_pin_in,
   input wire logic i_ext_fetch,
   input wire logic i_data_access,
   input wire logic i_data_write,
   input wire logic [7:0] i_port3_latch,
   input wire logic [7:0] i_port3_pin_in,
   output logic o_program_store_strobe_n,
   output logic o_program_store_strobe_oe,
   output logic [7:0] o_port3_out,
   output logic [7:0] o_port3_oe,
   output logic o_ext_irq_zero_in,
   output logic o_ext_irq_one_in,
   output logic o_count_in_zero,
   output logic o_count_in_one,
   output logic o_core_reset,
   output logic o_host_mode
);
   ////////////////////////////////////////////////////////////////
   // machine-cycle timing from the core clock
   localparam logic [7:0] P3_RST = `PORT3_RESET;
   localparam logic [4:0] RCNT_MAX = 5'h1f;
   logic phase_tick;
   logic mcycle_tick;
   logic half;
   mcycle_div #(
      .CLKS(CLKS)
   ) u_div (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .o_phase_tick(phase_tick),
      .o_mcycle_tick(mcycle_tick),
      .o_half(half)
   );
   ////////////////////////////////////////////////////////////////
   // pin synchronisers; first stage read only by second
   logic rst_s1_q;
   logic rst_s2_q;
   logic ps_s1_q;
   logic ps_s2_q;
   logic ps_prev_q;
   logic [7:0] p3_s1_q;
   logic [7:0] p3_s2_q;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
         ps_s1_q <= 1'b1;
         ps_s2_q <= 1'b1;
         ps_prev_q <= 1'b1;
         p3_s1_q <= P3_RST;
         p3_s2_q <= P3_RST;
      end else begin
         rst_s1_q <= i_reset_pin;
         rst_s2_q <= rst_s1_q;
         ps_s1_q <= i_strobe_pin_in;
         ps_s2_q <= ps_s1_q;
         ps_prev_q <= ps_s2_q;
         p3_s1_q <= i_port3_pin_in;
         p3_s2_q <= p3_s1_q;
      end
   end
   // edge history resets high, the pin's idle level: no false fall
   wire rst_hi = rst_s2_q;
   wire ps_fall = ps_prev_q & ~ps_s2_q;
   ////////////////////////////////////////////////////////////////
   // reset pin length in machine cycles, saturating
   logic [4:0] rcnt_q;
   logic [4:0] rcnt_d;
   logic fall_seen_q;
   logic fall_seen_d;
   op_mode_e mode_q;
   op_mode_e mode_d;
   wire long_reset = (rcnt_q > 5'(`HOST_RESET_MCYCLES));
   wire reset_valid = (rcnt_q >= 5'(`RESET_MIN_MCYCLES));
   wire rcnt_step = mcycle_tick & (rcnt_q != RCNT_MAX);
   wire in_reset = (mode_q == mode_reset);
   always_comb begin
      rcnt_d = rcnt_q;
      if (!rst_hi) begin
         rcnt_d = '0;
      end else if (rcnt_step) begin
         rcnt_d = rcnt_q + 5'h01;
      end
   end
   // a fall counts only after the long reset; a short one forgets it
   always_comb begin
      fall_seen_d = fall_seen_q;
      if (!rst_hi) begin
         fall_seen_d = fall_seen_q & in_reset;
      end else if (ps_fall && long_reset) begin
         fall_seen_d = 1'b1;
      end else if (!reset_valid) begin
         fall_seen_d = 1'b0;
      end
   end
   always_comb begin
      mode_d = mode_q;
      if (rst_hi && reset_valid) begin
         mode_d = mode_reset;
      end else if (!rst_hi && in_reset) begin
         mode_d = fall_seen_q ? mode_host : mode_normal;
      end
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rcnt_q <= '0;
         fall_seen_q <= 1'b0;
         mode_q <= mode_reset;
      end else begin
         rcnt_q <= rcnt_d;
         fall_seen_q <= fall_seen_d;
         mode_q <= mode_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   // program store strobe: one low pulse per half machine cycle
   logic [1:0] skip_q;
   logic [1:0] skip_d;
   logic pulse_q;
   logic pulse_d;
   wire running = (mode_q == mode_normal);
   wire fetching = running & i_ext_fetch;
   // data access is judged at the machine-cycle boundary only
   wire access_now = mcycle_tick & i_data_access & fetching;
   wire skipping = (skip_q != 2'h0);
   // the slot at this boundary and the next one are dropped
   always_comb begin
      skip_d = skip_q;
      if (access_now) begin
         skip_d = 2'h1;
      end else if (phase_tick && skipping) begin
         skip_d = skip_q - 2'h1;
      end
   end
   always_comb begin
      pulse_d = pulse_q;
      if (phase_tick) begin
         pulse_d = fetching & ~skipping & ~access_now;
      end
   end
   // high for the tick clock, so back-to-back slots stay two pulses
   wire strobe_low = pulse_q & fetching & ~phase_tick;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         skip_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         skip_q <= skip_d;
         pulse_q <= pulse_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   // port 3 alternate functions; data strobes own bits 6 and 7
   // strobes sit in the second half so address and data settle first
   wire data_rd = running & i_data_access & ~i_data_write & half;
   wire data_wr = running & i_data_access & i_data_write & half;
   wire [7:0] p3_force_low = {data_rd, data_wr, 6'h00};
   wire [7:0] p3_out_d;
   wire [7:0] p3_oe_d;
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_p3
         assign p3_out_d[b] = i_port3_latch[b] & ~p3_force_low[b];
         // a one releases the pin to its pull-up, so it reads as input
         assign p3_oe_d[b] = ~p3_out_d[b];
      end
   endgenerate
   ////////////////////////////////////////////////////////////////
   // registered outputs
   wire strobe_oe_d = running;
   wire core_reset_d = (mode_d == mode_reset);
   wire host_mode_d = (mode_d == mode_host);
   // released outside normal mode so a programmer can drive the pin
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_program_store_strobe_n <= 1'b1;
         o_program_store_strobe_oe <= 1'b0;
      end else begin
         o_program_store_strobe_n <= ~strobe_low;
         o_program_store_strobe_oe <= strobe_oe_d;
      end
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_port3_out <= P3_RST;
         o_port3_oe <= '0;
      end else begin
         o_port3_out <= p3_out_d;
         o_port3_oe <= p3_oe_d;
      end
   end
   // inputs only; edge and level sensing is the core's business
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ext_irq_zero_in <= 1'b1;
         o_ext_irq_one_in <= 1'b1;
         o_count_in_zero <= 1'b1;
         o_count_in_one <= 1'b1;
      end else begin
         o_ext_irq_zero_in <= p3_s2_q[2];
         o_ext_irq_one_in <= p3_s2_q[3];
         o_count_in_zero <= p3_s2_q[4];
         o_count_in_one <= p3_s2_q[5];
      end
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_core_reset <= 1'b1;
         o_host_mode <= 1'b0;
      end else begin
         o_core_reset <= core_reset_d;
         o_host_mode <= host_mode_d;
      end
   end
endmodule // ext_bus_strobes

// >>> bench/ext_bus_strobes_chk.sv
`timescale 1ns/1ps
module ext_bus_strobes_chk(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_reset_pin,
   input wire logic i_ext_fetch,
   input wire logic i_data_access,
   input wire logic i_data_write,
   input wire logic [7:0] i_port3_pin_in,
   input wire logic o_program_store_strobe_n,
   input wire logic [7:0] o_port3_out,
   input wire logic o_ext_irq_zero_in,
   input wire logic o_count_in_one,
   input wire logic o_core_reset,
   input wire logic o_host_mode
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   wire logic s_n = o_program_store_strobe_n;
   ////////////////////////////////////////////////////////////////
   property p_quiet; (!i_ext_fetch)[*4] |-> s_n; endproperty
   a_quiet: assert property (p_quiet) else $error("strobe on internal fetch");
   property p_pulse;
      (i_ext_fetch && !i_data_access && !o_core_reset && !o_host_mode)[*8] |-> ##[0:4] !s_n;
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe missing");
   property p_skip; $rose(i_data_access) |-> ##[1:4] s_n[*4]; endproperty
   a_skip: assert property (p_skip) else $error("no skipped pulses");
   property p_host; o_host_mode |-> s_n; endproperty
   a_host: assert property (p_host) else $error("strobe in host mode");
   property p_wr; (i_data_access && i_data_write)[*4] |-> ##[0:8] !o_port3_out[6]; endproperty
   a_wr: assert property (p_wr) else $error("no write strobe");
   property p_rd; (i_data_access && !i_data_write)[*4] |-> ##[0:8] !o_port3_out[7]; endproperty
   a_rd: assert property (p_rd) else $error("no read strobe");
   property p_irq0; ($stable(i_port3_pin_in[2]))[*5] |-> o_ext_irq_zero_in == i_port3_pin_in[2];
   endproperty
   a_irq0: assert property (p_irq0) else $error("irq zero input");
   property p_cnt1; ($stable(i_port3_pin_in[5]))[*5] |-> o_count_in_one == i_port3_pin_in[5];
   endproperty
   a_cnt1: assert property (p_cnt1) else $error("count one input");
   property p_rst; i_reset_pin[*8] ##1 i_reset_pin[*8] |-> o_core_reset; endproperty
   a_rst: assert property (p_rst) else $error("no core reset");
   c_fetch: cover property (i_ext_fetch && !s_n);
   c_host: cover property ($rose(o_host_mode));
   c_wr: cover property (i_data_access && i_data_write);
endmodule // ext_bus_strobes_chk

// >>> bench/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model(
   input wire logic i_strobe_n,
   input wire logic i_strobe_oe,
   input wire logic i_force_low,
   output logic o_pin,
   output int o_fetches = 0
);
   // pull-up holds the pin high while nobody drives it
   assign o_pin = i_strobe_oe ? i_strobe_n : !i_force_low;
   always @(negedge o_pin) if (i_strobe_oe) o_fetches++;
endmodule // ext_mem_model

// >>> bench/ext_bus_strobes_tb.sv
`timescale 1ns/1ps
module ext_bus_strobes_tb;
   logic i_clk = 0, i_rstn = 0, i_reset_pin = 0, i_ext_fetch = 0, i_data_access = 0;
   logic i_data_write = 0, frc = 0, i_strobe_pin_in, o_program_store_strobe_n;
   logic o_program_store_strobe_oe, o_ext_irq_zero_in, o_ext_irq_one_in, o_count_in_zero;
   logic o_count_in_one, o_core_reset, o_host_mode;
   logic [7:0] i_port3_latch = 8'hff, i_port3_pin_in, o_port3_out, o_port3_oe;
   logic [3:0] p3 = 4'hf;
   logic [1:0] lo;
   int fail_count = 0, n_checks = 0, cyc = 0, f0, fetches;
   // short machine cycle keeps the run brief
   ext_bus_strobes #(.CLKS(4)) dut_u (.*);
   ext_mem_model mem_u (.i_strobe_n(o_program_store_strobe_n),
      .i_strobe_oe(o_program_store_strobe_oe), .i_force_low(frc), .o_pin(i_strobe_pin_in),
      .o_fetches(fetches));
   assign i_port3_pin_in = {o_port3_out[7:6], p3, 2'h3};
   initial forever #20 i_clk = ~i_clk;
   always @(posedge i_clk) lo <= lo & o_port3_out[7:6];
   always @(posedge i_clk) if (++cyc == 3000) begin
      fail_count++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic w(int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic pin_reset(logic host);
      i_reset_pin = 1;
      w(48);
      frc = host;
      w(4);
      i_reset_pin = 0;
      w(12);
      frc = 0;
      chk("host", o_host_mode, host);
      chk("strobe_oe", o_program_store_strobe_oe, !host);
      chk("core_reset", o_core_reset, 0);
   endtask
   // window of four machine cycles, so phase does not change the count
   task automatic run(logic fe, logic da, logic dw, int exp);
      i_ext_fetch = fe;
      w(8);
      f0 = fetches;
      lo = 2'h3;
      i_data_access = da;
      i_data_write = dw;
      w(4);
      i_data_access = 0;
      w(12);
      chk("pulses", 8'(fetches - f0), 8'(exp));
      chk("rw_strobe", lo, da ? (dw ? 2'h2 : 2'h1) : 2'h3);
   endtask
   task automatic ports(logic [3:0] v);
      p3 = v;
      w(6);
      chk("irq0", o_ext_irq_zero_in, v[0]);
      chk("irq1", o_ext_irq_one_in, v[1]);
      chk("cnt0", o_count_in_zero, v[2]);
      chk("cnt1", o_count_in_one, v[3]);
      chk("p3_oe", o_port3_oe, 8'h00);
      chk("p3_out", o_port3_out, 8'hff);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      w(10);
      i_rstn = 1;
      pin_reset(0);
      run(0, 0, 0, 0);
      run(1, 0, 0, 8);
      run(1, 1, 1, 6);
      run(1, 1, 0, 6);
      i_ext_fetch = 0;
      ports(4'ha);
      ports(4'h5);
      pin_reset(1);
      pin_reset(0);
      print_verdict();
   end
endmodule // ext_bus_strobes_tb
bind ext_bus_strobes ext_bus_strobes_chk chk_u (.*);
